//--- verilog/sbpr_pkg.sv
package sbpr_pkg;
  // Base register addresses
  localparam logic [3:0] ADDR_NODE_ID = 4'h0;
  localparam logic [3:0] ADDR_RESET_GAP = 4'h1;
  localparam logic [3:0] ADDR_EXT_PORTS = 4'h2;
  localparam logic [3:0] ADDR_SPEED_DELAY = 4'h3;
  localparam logic [3:0] ADDR_LINK_POWER = 4'h4;
  localparam logic [3:0] ADDR_INT_FEATURE = 4'h5;
  localparam logic [3:0] ADDR_LEGACY_BRIDGE = 4'h6;
  localparam logic [3:0] ADDR_PAGE_PORT = 4'h7;
  // Field positions (bit 0 of the table is the msb, bit 7)
  localparam int ROOT_HOLDOFF_BIT = 7;
  localparam int LONG_RESET_BIT = 6;
  localparam int PAGE_LSB = 5;
  localparam int ROOT_BIT = 1;
  localparam int POWER_BIT = 0;
  // Reset and constant values
  localparam logic [5:0] GAP_RESET = 6'h3f;
  localparam logic [2:0] EXTENDED_VALUE = 3'h7;
  localparam logic [3:0] PORT_COUNT = 4'h3;
  localparam logic [2:0] LEGACY_SPEED = 3'h7;
  localparam logic [3:0] REPEATER_DELAY = 4'h2;
  localparam logic [2:0] PAGE_RESET = 3'h0;
  localparam logic [3:0] PORT_SEL_RESET = 4'h0;
  // Long bus reset length
  localparam int LONG_RESET_US = 166;
  localparam int CLOCK_MHZ = 125;
  localparam int LONG_RESET_CYCLES = LONG_RESET_US * CLOCK_MHZ;
endpackage

//--- verilog/sbpr_regs.sv
`timescale 1ns/10ps
// Contract
// - Sixteen registers, upper eight paged
// - Page select in base register 7
// - Base registers ignore page selection
// - Reserved registers and fields read zero
// - Pages two to six all reserved
// - Read-only node address, status on completion
// - Root flag cleared on reset, set if root
// - Cable power flag mirrors sense input
// - Root holdoff survives bus reset
// - Long reset request starts 166 us reset
// - Running packet finishes before reset
// - Request cleared by any reset
// - Gap count from write or packet
// - Gap 3Fh after two idle resets
// - Extended indicator reads 111b
// - Port count reads three
// - Legacy speed reads 111b
// - Repeater delay reads 02h
module sbpr_regs #(
  parameter int LONG_RESET_CYCLES = sbpr_pkg::LONG_RESET_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] page_data_in,
  input wire logic cable_power_in,
  input wire logic bus_reset_in,
  input wire logic self_id_done_in,
  input wire logic [5:0] self_id_addr_in,
  input wire logic became_root_in,
  input wire logic config_gap_valid_in,
  input wire logic [5:0] config_gap_in,
  input wire logic config_holdoff_valid_in,
  input wire logic config_holdoff_in,
  input wire logic link_busy_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic status_push_out,
  output logic [7:0] status_data_out,
  output logic long_reset_active_out,
  output logic root_holdoff_out,
  output logic [5:0] gap_count_out,
  output logic [2:0] page_select_out,
  output logic [3:0] port_select_out
);

  typedef enum logic [2:0] {
    SBPR_IDLE = 3'b001,
    SBPR_WAIT = 3'b010,
    SBPR_RESET = 3'b100
  } sbpr_state_t;

  sbpr_state_t state;
  logic [5:0] node_bus_address;
  logic root;
  logic [2:0] pwr_sync;
  logic cable_power_flag;
  logic long_bus_reset_request;
  logic gap_touched;
  logic [31:0] reset_count;
  logic [7:0] next_read;
  logic wr_gap;
  logic wr_page;
  logic set_long_req;
  logic [7:0] image_node;
  logic [7:0] image_gap;
  logic [7:0] image_ports;
  logic [7:0] image_delay;
  logic [7:0] image_page;
  logic page_reserved;

  // Write strobes for the two writable base registers
  assign wr_gap = wr_en_in && (addr_in == sbpr_pkg::ADDR_RESET_GAP);
  assign wr_page = wr_en_in && (addr_in == sbpr_pkg::ADDR_PAGE_PORT);
  assign set_long_req = wr_gap && wr_data_in[sbpr_pkg::LONG_RESET_BIT];

  // Register images, built once so the read mux stays flat
  assign image_node = {node_bus_address, root, cable_power_flag};
  assign image_gap = {root_holdoff_out, long_bus_reset_request, gap_count_out};
  assign image_ports = {sbpr_pkg::EXTENDED_VALUE, 1'b0, sbpr_pkg::PORT_COUNT};
  assign image_delay = {sbpr_pkg::LEGACY_SPEED, 1'b0, sbpr_pkg::REPEATER_DELAY};
  assign image_page = {page_select_out, 1'b0, port_select_out};
  assign page_reserved = (page_select_out >= 3'h2) && (page_select_out <= 3'h6);

  // Node address latched at self-id end
  // address capture
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      node_bus_address <= 6'h00;
    end else if (self_id_done_in) begin
      node_bus_address <= self_id_addr_in;
    end
  end

  // Unsolicited register 0 transfer to the link
  // status push
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      status_push_out <= 1'b0;
      status_data_out <= 8'h00;
    end else begin
      status_push_out <= self_id_done_in;
      if (self_id_done_in) begin
        // Root and power as they stand now; later changes show on read
        status_data_out <= {self_id_addr_in, root, cable_power_flag};
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      root <= 1'b0;
    end else if (bus_reset_in) begin
      root <= 1'b0;
    end else if (became_root_in) begin
      root <= 1'b1;
    end
  end

  // Pin crosses three stages; change taken once last two agree
  // cable power mirror
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pwr_sync <= 3'b000;
      cable_power_flag <= 1'b0;
    end else begin
      pwr_sync <= {pwr_sync[1:0], cable_power_in};
      if (pwr_sync[1] == pwr_sync[2]) begin
        cable_power_flag <= pwr_sync[2];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      root_holdoff_out <= 1'b0;
    end else if (config_holdoff_valid_in) begin
      root_holdoff_out <= config_holdoff_in;
    end else if (wr_gap) begin
      root_holdoff_out <= wr_data_in[sbpr_pkg::ROOT_HOLDOFF_BIT];
    end
  end

  // Gap count; a packet beats a same-cycle register write
  // write or packet update
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      gap_count_out <= sbpr_pkg::GAP_RESET;
    end else if (config_gap_valid_in) begin
      gap_count_out <= config_gap_in;
    end else if (wr_gap) begin
      gap_count_out <= wr_data_in[5:0];
    end else if (bus_reset_in && !gap_touched) begin
      gap_count_out <= sbpr_pkg::GAP_RESET;
    end
  end

  // Update tracker; an update meeting a reset counts for it
  // updates between resets
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      gap_touched <= 1'b0;
    end else if (config_gap_valid_in || wr_gap) begin
      gap_touched <= 1'b1;
    end else if (bus_reset_in) begin
      gap_touched <= 1'b0;
    end
  end

  // Request bit; a new write beats a same-cycle bus reset clear
  // cleared on resets
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      long_bus_reset_request <= 1'b0;
    end else if (set_long_req) begin
      long_bus_reset_request <= 1'b1;
    end else if (bus_reset_in || state == SBPR_RESET) begin
      long_bus_reset_request <= 1'b0;
    end
  end

  // Long reset sequencer; waits for the link to go quiet first
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= SBPR_IDLE;
      long_reset_active_out <= 1'b0;
    end else begin
      case (state)
        SBPR_IDLE: begin
          if (long_bus_reset_request) begin
            state <= SBPR_WAIT;
          end
        end
        SBPR_WAIT: begin
          if (!link_busy_in) begin
            state <= SBPR_RESET;
            long_reset_active_out <= 1'b1;
          end
        end
        SBPR_RESET: begin
          if (reset_count == 32'h0000_0000) begin
            state <= SBPR_IDLE;
            long_reset_active_out <= 1'b0;
          end
        end
        default: begin
          state <= SBPR_IDLE;
          long_reset_active_out <= 1'b0;
        end
      endcase
    end
  end

  // Length counter, loaded as the reset starts and run down inside it
  // reset length
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      reset_count <= 32'h0000_0000;
    end else if (state == SBPR_WAIT && !link_busy_in) begin
      reset_count <= 32'(LONG_RESET_CYCLES - 1);
    end else if (state == SBPR_RESET && reset_count != 32'h0000_0000) begin
      reset_count <= reset_count - 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      page_select_out <= sbpr_pkg::PAGE_RESET;
    end else if (wr_page) begin
      page_select_out <= wr_data_in[sbpr_pkg::PAGE_LSB +: 3];
    end
  end

  // Port selector; only steers paged content outside this block
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      port_select_out <= sbpr_pkg::PORT_SEL_RESET;
    end else if (wr_page) begin
      port_select_out <= wr_data_in[3:0];
    end
  end

  // Read mux; registers 4h-6h belong elsewhere and read zero here
  // sixteen-entry decode
  always_comb begin
    next_read = 8'h00;
    if (addr_in == sbpr_pkg::ADDR_NODE_ID) begin
      next_read = image_node;
    end else if (addr_in == sbpr_pkg::ADDR_RESET_GAP) begin
      next_read = image_gap;
    end else if (addr_in == sbpr_pkg::ADDR_EXT_PORTS) begin
      next_read = image_ports;
    end else if (addr_in == sbpr_pkg::ADDR_SPEED_DELAY) begin
      next_read = image_delay;
    end else if (addr_in == sbpr_pkg::ADDR_PAGE_PORT) begin
      next_read = image_page;
    end else if (addr_in[3]) begin
      if (!page_reserved) begin
        next_read = page_data_in;
      end
    end
  end

  // Read valid pulse, one cycle after strobe
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
    end
  end

  // Read data, zero between reads so no stale value shows
  // read-only fields never stored
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= rd_en_in ? next_read : 8'h00;
    end
  end

endmodule

//--- verification/sbpr_link.sv
`timescale 1ns/10ps
// Link side model, one request at a time
module sbpr_link (
  input wire logic clock_in,
  input wire logic [7:0] rd_data_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [3:0] addr_out,
  output logic [7:0] wr_data_out
);
  logic [7:0] last_rd;
  initial begin
    wr_en_out <= 1'b0;
    rd_en_out <= 1'b0;
    addr_out <= 4'h0;
    wr_data_out <= 8'h00;
  end
  // Address inverted after a write so no stale value lingers
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wr_data_out <= d;
    @(posedge clock_in);
    wr_en_out <= 1'b0;
    addr_out <= ~a;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock_in);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge clock_in);
    rd_en_out <= 1'b0;
    // Answer launched at the edge above is still standing here
    @(posedge clock_in);
    last_rd = rd_data_in;
  endtask
  task automatic long_reset();
    rd(4'h1);
    wr(4'h1, last_rd | 8'h40);
  endtask
endmodule

//--- verification/sbpr_chk.sv
`timescale 1ns/10ps
module sbpr_chk #(
  parameter int LONG_RESET_CYCLES = 20
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [3:0] addr_in,
  input wire logic bus_reset_in,
  input wire logic self_id_done_in,
  input wire logic [5:0] self_id_addr_in,
  input wire logic config_gap_valid_in,
  input wire logic [5:0] config_gap_in,
  input wire logic config_holdoff_valid_in,
  input wire logic link_busy_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic status_push_out,
  input wire logic [7:0] status_data_out,
  input wire logic long_reset_active_out,
  input wire logic root_holdoff_out,
  input wire logic [5:0] gap_count_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Cycles spent in the long reset so far
  int active_len;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !long_reset_active_out) begin
      active_len <= 0;
    end else begin
      active_len <= active_len + 1;
    end
  end
  sequence read_of(logic [3:0] a);
    rd_en_in && addr_in == a;
  endsequence
  AST_READ_PULSE: assert property (rd_valid_out == $past(rd_en_in)) else $error("read pulse");
  AST_RSVD_ZERO: assert property (read_of(4'h4) or read_of(4'h5) or read_of(4'h6) |=> rd_data_out == 8'h00)
    else $error("reserved read");
  AST_EXT_PORTS: assert property (read_of(4'h2) |=> rd_data_out == 8'he3) else $error("ext ports");
  AST_SPEED_DELAY: assert property (read_of(4'h3) |=> rd_data_out == 8'he2) else $error("speed delay");
  AST_STATUS_PUSH: assert property (self_id_done_in |=> status_push_out
    && status_data_out[7:2] == $past(self_id_addr_in)) else $error("status push");
  AST_GAP_PACKET: assert property (config_gap_valid_in |=> gap_count_out == $past(config_gap_in)) else $error("gap pkt");
  AST_HOLDOFF_KEPT: assert property (bus_reset_in && !config_holdoff_valid_in && !(wr_en_in && addr_in == 4'h1)
    |=> $stable(root_holdoff_out)) else $error("holdoff lost");
  AST_WAIT_BUSY: assert property (link_busy_in && !long_reset_active_out |=> !long_reset_active_out)
    else $error("reset while busy");
  AST_LONG_LEN: assert property ($fell(long_reset_active_out) |-> active_len == LONG_RESET_CYCLES)
    else $error("reset length");
endmodule
bind sbpr_regs sbpr_chk #(.LONG_RESET_CYCLES(LONG_RESET_CYCLES)) u_chk (.clock_in, .rst_n_in, .wr_en_in, .rd_en_in,
  .addr_in, .bus_reset_in, .self_id_done_in, .self_id_addr_in, .config_gap_valid_in, .config_gap_in,
  .config_holdoff_valid_in, .link_busy_in, .rd_data_out, .rd_valid_out, .status_push_out, .status_data_out,
  .long_reset_active_out, .root_holdoff_out, .gap_count_out);

//--- verification/sbpr_regs_tb.sv
`timescale 1ns/10ps
module sbpr_regs_tb;
  logic clock_in = 1'b0, rst_n_in, wr_en_in, rd_en_in, cable_power_in, bus_reset_in;
  logic self_id_done_in, became_root_in, config_gap_valid_in, link_busy_in;
  logic config_holdoff_valid_in, config_holdoff_in, rd_valid_out, status_push_out;
  logic long_reset_active_out, root_holdoff_out;
  logic [3:0] addr_in;
  logic [7:0] wr_data_in, page_data_in, rd_data_out, status_data_out, v, g;
  logic [5:0] self_id_addr_in, config_gap_in, gap_count_out;
  logic [7:0] base_rst [8] = '{8'h01, 8'h3f, 8'he3, 8'he2, 8'h00, 8'h00, 8'h00, 8'h00};
  int err_count = 0, num_checks = 0, seed = 32'he214a677;
  initial begin
    forever #4 clock_in = ~clock_in;
  end
  sbpr_link link (.clock_in, .rd_data_in(rd_data_out), .wr_en_out(wr_en_in), .rd_en_out(rd_en_in),
    .addr_out(addr_in), .wr_data_out(wr_data_in));
  sbpr_regs #(.LONG_RESET_CYCLES(20)) DUT (.clock_in, .rst_n_in, .wr_en_in, .rd_en_in, .addr_in, .wr_data_in,
    .page_data_in, .cable_power_in, .bus_reset_in, .self_id_done_in, .self_id_addr_in, .became_root_in,
    .config_gap_valid_in, .config_gap_in, .config_holdoff_valid_in, .config_holdoff_in, .link_busy_in,
    .rd_data_out, .rd_valid_out, .status_push_out, .status_data_out, .long_reset_active_out, .root_holdoff_out,
    .gap_count_out, .page_select_out(), .port_select_out());
  // Paged content shows only on pages 0, 1 and 7
  function automatic logic [7:0] paged(input logic [2:0] p, input logic [7:0] d);
    return (p < 3'h2 || p == 3'h7) ? d : 8'h00;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bres();
    @(posedge clock_in) bus_reset_in <= 1'b1;
    @(posedge clock_in) bus_reset_in <= 1'b0;
  endtask
  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
  initial begin
    rst_n_in <= 1'b0;
    cable_power_in <= 1'b1;
    bus_reset_in <= 1'b0;
    self_id_done_in <= 1'b0;
    became_root_in <= 1'b0;
    config_gap_valid_in <= 1'b0;
    link_busy_in <= 1'b0;
    config_holdoff_valid_in <= 1'b0;
    config_holdoff_in <= 1'b0;
    page_data_in <= 8'h00;
    self_id_addr_in <= 6'h00;
    config_gap_in <= 6'h00;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    for (int i = 0; i < 8; i++) begin
      link.rd(4'(i));
      chk(link.last_rd, base_rst[i]);
    end
    repeat (6) begin
      v = 8'($random(seed)) & 8'h3f;
      g = v;
      link.wr(4'h1, v);
      link.wr(4'h2, ~v);
      link.rd(4'h1);
      chk(link.last_rd, v);
      link.rd(4'h2);
      chk(link.last_rd, 8'he3);
    end
    for (int p = 0; p < 8; p++) begin
      v = 8'($random(seed));
      page_data_in <= v;
      link.wr(4'h7, {3'(p), 1'b1, v[3:0]});
      link.rd(4'h7);
      chk(link.last_rd, {3'(p), 1'b0, v[3:0]});
      link.rd({1'b1, v[6:4]});
      chk(link.last_rd, paged(3'(p), v));
      link.rd(4'h3);
      chk(link.last_rd, 8'he2);
    end
    config_holdoff_valid_in <= 1'b1;
    config_holdoff_in <= 1'b1;
    @(posedge clock_in) config_holdoff_valid_in <= 1'b0;
    bres();
    link.rd(4'h1);
    chk(link.last_rd, {2'b10, g[5:0]});
    bres();
    link.rd(4'h1);
    chk(link.last_rd, 8'hbf);
    config_gap_in <= v[5:0] ^ 6'h2a;
    config_gap_valid_in <= 1'b1;
    @(posedge clock_in) config_gap_valid_in <= 1'b0;
    self_id_addr_in <= v[7:2];
    became_root_in <= 1'b1;
    @(posedge clock_in) became_root_in <= 1'b0;
    self_id_done_in <= 1'b1;
    @(posedge clock_in) self_id_done_in <= 1'b0;
    @(posedge clock_in);
    chk(status_data_out, {v[7:2], 2'b11});
    bres();
    link.rd(4'h0);
    chk({7'h0, link.last_rd[1]}, 8'h00);
    cable_power_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    link.rd(4'h0);
    chk({7'h0, link.last_rd[0]}, 8'h00);
    link_busy_in <= 1'b1;
    link.long_reset();
    repeat (10) @(posedge clock_in);
    chk({7'h0, long_reset_active_out}, 8'h00);
    link_busy_in <= 1'b0;
    for (int n = 0; n < 20 && !long_reset_active_out; n++) @(posedge clock_in);
    chk({7'h0, long_reset_active_out}, 8'h01);
    link.rd(4'h1);
    chk(link.last_rd, {2'b10, v[5:0] ^ 6'h2a});
    repeat (30) @(posedge clock_in);
    give_verdict();
  end
endmodule
